// ---- rtl/servo_io_map.svh ----
// constants for the servo i/o signal allocation block
// Functional notes
// - five input pins, each mapped by one field
// - one pin drives every function allocated to it
// - function repeated on pins: highest priority pin only
// - input codes zero to nine decoded as listed
// - three output groups, one map field each
// - output group drives OR of allocated functions
// - output codes zero to eight, A, B decoded
// - internal torque limit always applied
// - external limit applied while cap input asserted
// - network positive and negative limits applied too
// - effective limit clamped to motor maximum torque
// - brake unassigned after reset; active releases brake
`ifndef SERVO_IO_MAP_SVH
`define SERVO_IO_MAP_SVH
`define IN_PINS          5
`define OUT_GROUPS       3
`define FIELD_W          4
`define IN_FNS           10
`define OUT_FNS          12
`define FN_SERVO_ENABLE  4'h0
`define FN_FWD_PROHIBIT  4'h1
`define FN_REV_PROHIBIT  4'h2
`define FN_FWD_CAP       4'h3
`define FN_REV_CAP       4'h4
`define FN_GAIN_SWITCH   4'h5
`define FN_HOMING        4'h6
`define FN_HOST_IN       4'h7
`define FN_PROBE_A       4'h8
`define FN_PROBE_B       4'h9
`define OF_POS_DONE      4'h0
`define OF_SPIN          4'h1
`define OF_READY         4'h2
`define OF_CLAMPED       4'h3
`define OF_BRAKE         4'h4
`define OF_INDEX         4'h5
`define OF_TRAVEL        4'h6
`define OF_EXCITED       4'h7
`define OF_TORQUE_DET    4'h8
`define OF_HOST_0        4'hA
`define OF_HOST_1        4'hB
`define MAP_UNASSIGNED   4'hF
`define IN_MAP_A_RESET   16'hFFFF
`define IN_MAP_B_RESET   4'hF
`define OUT_MAP_RESET    12'hFFF
`define TORQUE_W         9
`endif

// ---- rtl/servo_io_pkg.sv ----
// types shared by the servo i/o signal allocation block
package servo_io_pkg;
	typedef logic [3:0] fn_code_type;
	typedef logic [8:0] torque_pct_type;
endpackage : servo_io_pkg

// ---- rtl/servo_io_signal_allocation.sv ----
// servo i/o pin allocation, output mux and torque limit selection
`timescale 1ns/1ps
`include "servo_io_map.svh"
module servo_io_signal_allocation
	import servo_io_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic [4:0]           io_connector_in,
	input  wire logic [15:0]          input_map_word_a,
	input  wire logic [3:0]           input_map_word_b,
	input  wire logic [11:0]          output_map_word,
	input  wire logic                 map_load,
	input  wire logic                 position_done_out,
	input  wire logic                 spin_detect_out,
	input  wire logic                 servo_ready,
	input  wire logic                 holding_brake_out,
	input  wire logic                 index_pulse_out,
	input  wire logic                 motor_excited,
	input  wire logic                 torque_detect_out,
	input  wire logic                 host_io_out_0,
	input  wire logic                 host_io_out_1,
	input  wire torque_pct_type       fwd_internal_cap,
	input  wire torque_pct_type       rev_internal_cap,
	input  wire torque_pct_type       fwd_external_cap,
	input  wire torque_pct_type       rev_external_cap,
	input  wire torque_pct_type       pos_torque_cap_obj,
	input  wire torque_pct_type       neg_torque_cap_obj,
	input  wire torque_pct_type       motor_max_torque,
	input  wire torque_pct_type       torque_request,
	input  wire logic                 torque_request_rev,
	output logic                      servo_enable_in,
	output logic                      fwd_prohibit_in,
	output logic                      rev_prohibit_in,
	output logic                      fwd_torque_cap_in,
	output logic                      rev_torque_cap_in,
	output logic                      proportional_ctl_in,
	output logic                      homing_in,
	output logic                      host_io_in,
	output logic                      probe_a_in,
	output logic                      probe_b_in,
	output logic [2:0]                io_connector_out,
	output torque_pct_type            fwd_torque_limit,
	output torque_pct_type            rev_torque_limit,
	output torque_pct_type            torque_out,
	output logic                      torque_clamped_out,
	output logic                      travel_limit_out
);

	// ********************************
	// allocation words
	// ********************************
	// maps are captured on map_load so a half-written word never reaches pins
	logic [15:0] in_map_a_r;
	logic [3:0]  in_map_b_r;
	logic [11:0] out_map_r;
	fn_code_type in_code [`IN_PINS];

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			in_map_a_r <= `IN_MAP_A_RESET;
			in_map_b_r <= `IN_MAP_B_RESET;
			out_map_r  <= `OUT_MAP_RESET;
		end
		else if (map_load)
		begin
			in_map_a_r <= input_map_word_a;
			in_map_b_r <= input_map_word_b;
			out_map_r  <= output_map_word;
		end
	end

	always_comb
	begin
		for (int p = 0; p < 4; p++)
			in_code[p] = in_map_a_r[p*4 +: 4];
		in_code[4] = in_map_b_r;
	end

	// ********************************
	// pin synchronisers
	// ********************************
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic [4:0] sync3_r;
	logic [4:0] pin_r;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			sync1_r <= 5'h0_0;
			sync2_r <= 5'h0_0;
			sync3_r <= 5'h0_0;
		end
		else
		begin
			sync1_r <= io_connector_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (!rstn)
			pin_r <= 5'h0_0;
		else
			for (int p = 0; p < `IN_PINS; p++)
				if (sync2_r[p] == sync3_r[p])
					pin_r[p] <= sync3_r[p];
	end

	// ********************************
	// input function decode
	// ********************************
	logic [`IN_FNS-1:0] fn_nxt;
	logic [`IN_FNS-1:0] fn_r;

	always_comb
	begin
		fn_nxt = '0;
		for (int f = 0; f < `IN_FNS; f++)
			// ascending scan: later (higher numbered) pin overrides
			for (int p = 0; p < `IN_PINS; p++)
				if (in_code[p] == 4'(f))
					fn_nxt[f] = pin_r[p];
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			fn_r <= '0;
		else
			fn_r <= fn_nxt;
	end

	assign servo_enable_in     = fn_r[`FN_SERVO_ENABLE];
	assign fwd_prohibit_in     = fn_r[`FN_FWD_PROHIBIT];
	assign rev_prohibit_in     = fn_r[`FN_REV_PROHIBIT];
	assign fwd_torque_cap_in   = fn_r[`FN_FWD_CAP];
	assign rev_torque_cap_in   = fn_r[`FN_REV_CAP];
	assign proportional_ctl_in = fn_r[`FN_GAIN_SWITCH];
	assign homing_in           = fn_r[`FN_HOMING];
	assign host_io_in          = fn_r[`FN_HOST_IN];
	assign probe_a_in          = fn_r[`FN_PROBE_A];
	assign probe_b_in          = fn_r[`FN_PROBE_B];

	// ********************************
	// torque limit selection
	// ********************************
	function automatic torque_pct_type min2(torque_pct_type a, torque_pct_type b);
		return (a < b) ? a : b;
	endfunction : min2

	torque_pct_type fwd_lim_nxt;
	torque_pct_type rev_lim_nxt;
	torque_pct_type lim_sel;

	always_comb
	begin
		fwd_lim_nxt = fwd_internal_cap;
		rev_lim_nxt = rev_internal_cap;
		if (fn_r[`FN_FWD_CAP])
			fwd_lim_nxt = min2(fwd_lim_nxt, fwd_external_cap);
		if (fn_r[`FN_REV_CAP])
			rev_lim_nxt = min2(rev_lim_nxt, rev_external_cap);
		fwd_lim_nxt = min2(fwd_lim_nxt, pos_torque_cap_obj);
		rev_lim_nxt = min2(rev_lim_nxt, neg_torque_cap_obj);
		fwd_lim_nxt = min2(fwd_lim_nxt, motor_max_torque);
		rev_lim_nxt = min2(rev_lim_nxt, motor_max_torque);
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			fwd_torque_limit <= '0;
			rev_torque_limit <= '0;
		end
		else
		begin
			fwd_torque_limit <= fwd_lim_nxt;
			rev_torque_limit <= rev_lim_nxt;
		end
	end

	// limits lag the inputs by one cycle; the clamp uses the registered pair
	assign lim_sel = torque_request_rev ? rev_torque_limit : fwd_torque_limit;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			torque_out         <= '0;
			torque_clamped_out <= 1'b0;
		end
		else
		begin
			torque_out         <= min2(torque_request, lim_sel);
			torque_clamped_out <= (torque_request > lim_sel);
		end
	end

	// ********************************
	// output group mux
	// ********************************
	logic [`OUT_FNS-1:0] ofn;
	logic [2:0]          out_nxt;

	always_comb
	begin
		ofn                = '0;
		ofn[`OF_POS_DONE]  = position_done_out;
		ofn[`OF_SPIN]      = spin_detect_out;
		ofn[`OF_READY]     = servo_ready;
		ofn[`OF_CLAMPED]   = torque_clamped_out;
		ofn[`OF_BRAKE]     = holding_brake_out;
		ofn[`OF_INDEX]     = index_pulse_out;
		ofn[`OF_TRAVEL]    = travel_limit_out;
		ofn[`OF_EXCITED]   = motor_excited;
		ofn[`OF_TORQUE_DET] = torque_detect_out;
		ofn[`OF_HOST_0]    = host_io_out_0;
		ofn[`OF_HOST_1]    = host_io_out_1;
		for (int g = 0; g < `OUT_GROUPS; g++)
		begin
			out_nxt[g] = 1'b0;
			for (int f = 0; f < `OUT_FNS; f++)
				if (out_map_r[g*4 +: 4] == 4'(f))
					out_nxt[g] = out_nxt[g] | ofn[f];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			io_connector_out <= 3'h0;
			travel_limit_out <= 1'b0;
		end
		else
		begin
			io_connector_out <= out_nxt;
			travel_limit_out <= fn_r[`FN_FWD_PROHIBIT] | fn_r[`FN_REV_PROHIBIT];
		end
	end

	// ********************************
	// assertions
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_pin_top_wins: assert property (
		(in_code[4] == `FN_HOMING) |=> (homing_in == $past(pin_r[4])))
		else $error("homing not taken from top pin");
	a_pin_order: assert property (
		(in_code[3] == `FN_PROBE_A && in_code[4] != `FN_PROBE_A)
		|=> (probe_a_in == $past(pin_r[3])))
		else $error("pin priority wrong");
	a_unalloc_idle: assert property (
		(in_code[0] != `FN_SERVO_ENABLE && in_code[1] != `FN_SERVO_ENABLE
		&& in_code[2] != `FN_SERVO_ENABLE && in_code[3] != `FN_SERVO_ENABLE
		&& in_code[4] != `FN_SERVO_ENABLE) |=> !servo_enable_in)
		else $error("unallocated function active");
	a_pin_filter: assert property (
		(sync2_r[0] != sync3_r[0]) |=> (pin_r[0] == $past(pin_r[0])))
		else $error("pin changed on disagreement");
	a_int_limit: assert property (
		fwd_torque_limit <= $past(fwd_internal_cap) || $fell(rstn))
		else $error("internal limit exceeded");
	a_ext_limit: assert property (
		fn_r[`FN_REV_CAP] |=> (rev_torque_limit <= $past(rev_external_cap)))
		else $error("external limit ignored");
	a_obj_limit: assert property (
		##1 (rev_torque_limit <= $past(neg_torque_cap_obj)))
		else $error("network limit ignored");
	a_motor_max: assert property (
		##1 (fwd_torque_limit <= $past(motor_max_torque)))
		else $error("limit above motor maximum");
	a_brake_group: assert property (
		(out_map_r[3:0] == `OF_BRAKE) |=> (io_connector_out[0] == $past(holding_brake_out)))
		else $error("brake group mismatch");
	a_group_ready: assert property (
		(out_map_r[11:8] == `OF_READY) |=> (io_connector_out[2] == $past(servo_ready)))
		else $error("ready group mismatch");
	a_group_none: assert property (
		(out_map_r[7:4] == `MAP_UNASSIGNED) |=> !io_connector_out[1])
		else $error("unassigned group active");

	c_fwd_cap: cover property (fn_r[`FN_FWD_CAP] ##1 torque_clamped_out);
	c_brake_out: cover property ((out_map_r[3:0] == `OF_BRAKE) ##1 io_connector_out[0]);
	c_shared_fn: cover property ((in_code[1] == in_code[4]) && pin_r[1] && !pin_r[4]);

endmodule : servo_io_signal_allocation

// ---- bench/field_wiring.sv ----
// field side model: connector pin wiring from the host controller
`timescale 1ns/1ps
module field_wiring
(
	input  wire logic       clk,
	input  wire logic [4:0] pin_level,
	output logic [4:0]      io_connector_in
);
	// ****************************************
	// pin drive
	// ****************************************
	// host holds a cap pin up for as long as reduced torque is wanted
	// one driver only: the synchronisers are held in reset while rstn is low
	// switches move on the falling edge, away from the sampling edge
	always_ff @(negedge clk) io_connector_in <= pin_level;
endmodule : field_wiring

// ---- bench/servo_io_signal_allocation_bench.sv ----
// bench for the servo i/o signal allocation block
`timescale 1ns/1ps
module servo_io_signal_allocation_bench;
	import servo_io_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic clk, rstn, map_load, torque_request_rev;
	logic [4:0] pin_level, io_connector_in;
	logic [15:0] input_map_word_a;
	logic [3:0] input_map_word_b;
	logic [11:0] output_map_word;
	logic [8:0] st;
	logic [2:0] io_connector_out;
	torque_pct_type fwd_internal_cap, rev_internal_cap, fwd_external_cap, rev_external_cap;
	torque_pct_type pos_torque_cap_obj, neg_torque_cap_obj, motor_max_torque, torque_request;
	torque_pct_type fwd_torque_limit, rev_torque_limit, torque_out;
	logic servo_enable_in, fwd_prohibit_in, rev_prohibit_in, fwd_torque_cap_in;
	logic rev_torque_cap_in, proportional_ctl_in, homing_in, host_io_in, probe_a_in;
	logic probe_b_in, torque_clamped_out, travel_limit_out;
	logic [9:0] fn;
	logic [35:0] ocodes;
	int failures, checked, cycles;
	assign fn = {probe_b_in, probe_a_in, host_io_in, homing_in, proportional_ctl_in,
		rev_torque_cap_in, fwd_torque_cap_in, rev_prohibit_in, fwd_prohibit_in, servo_enable_in};
	assign ocodes = 36'hB_A875_4210;
	field_wiring field_wiring_inst (.clk, .pin_level, .io_connector_in);
	servo_io_signal_allocation servo_io_signal_allocation_inst (
		.clk, .rstn, .io_connector_in, .input_map_word_a, .input_map_word_b,
		.output_map_word, .map_load, .position_done_out(st[0]), .spin_detect_out(st[1]),
		.servo_ready(st[2]), .holding_brake_out(st[3]), .index_pulse_out(st[4]),
		.motor_excited(st[5]), .torque_detect_out(st[6]), .host_io_out_0(st[7]),
		.host_io_out_1(st[8]), .fwd_internal_cap, .rev_internal_cap, .fwd_external_cap,
		.rev_external_cap, .pos_torque_cap_obj, .neg_torque_cap_obj, .motor_max_torque,
		.torque_request, .torque_request_rev, .servo_enable_in, .fwd_prohibit_in,
		.rev_prohibit_in, .fwd_torque_cap_in, .rev_torque_cap_in, .proportional_ctl_in,
		.homing_in, .host_io_in, .probe_a_in, .probe_b_in, .io_connector_out,
		.fwd_torque_limit, .rev_torque_limit, .torque_out, .torque_clamped_out,
		.travel_limit_out);
	// ****************************************
	// tasks
	// ****************************************
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task load(input logic [19:0] im, input logic [11:0] om);
		{input_map_word_b, input_map_word_a} = im;
		output_map_word = om;
		map_load = 1'b1;
		@(negedge clk);
		map_load = 1'b0;
		repeat (3) @(negedge clk);
	endtask : load
	// pins pass a 3 flop filter, so allow well over the 5 edge latency
	task pins(input logic [4:0] lv);
		pin_level = lv;
		repeat (8) @(negedge clk);
	endtask : pins
	task complete_run;
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	// ****************************************
	// clock, timeout, tests
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			complete_run();
		end
	end
	initial
	begin
		failures = 0;
		checked = 0;
		cycles = 0;
		rstn = 1'b0;
		map_load = 1'b0;
		pin_level = 5'h00;
		st = 9'h1FF;
		{input_map_word_b, input_map_word_a} = 20'hF_FFFF;
		output_map_word = 12'hFFF;
		{fwd_internal_cap, rev_internal_cap} = {9'h12C, 9'h12C};
		{fwd_external_cap, rev_external_cap} = {9'h064, 9'h064};
		{pos_torque_cap_obj, neg_torque_cap_obj} = {9'h0C8, 9'h0C8};
		motor_max_torque = 9'h0FA;
		torque_request = 9'h118;
		torque_request_rev = 1'b0;
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		chk(io_connector_out, 16'h0000);
		pins(5'h1F);
		chk(fn, 16'h0000);
		for (int p = 0; p < 5; p++)
			for (int c = 0; c < 10; c++)
			begin
				load(20'hF_FFFF & ~(20'hF << (4 * p)) | (20'(c) << (4 * p)), 12'hFFF);
				pins(5'h1F);
				chk(fn, 16'h0001 << c);
				chk(travel_limit_out, (c == 1 || c == 2));
				pins(5'h00);
				chk(fn, 16'h0000);
			end
		load(20'h0_FFF0, 12'hFFF);
		pins(5'h01);
		chk(servo_enable_in, 16'h0000);
		pins(5'h10);
		chk(servo_enable_in, 16'h0001);
		pins(5'h00);
		st = 9'h000;
		for (int g = 0; g < 3; g++)
			for (int k = 0; k < 9; k++)
			begin
				load(20'hF_FFFF, 12'hFFF & ~(12'hF << (4 * g)) | (12'(ocodes[4*k+:4]) << (4 * g)));
				st = 9'h001 << k;
				repeat (3) @(negedge clk);
				chk(io_connector_out, 16'h0001 << g);
				st = 9'h000;
				repeat (3) @(negedge clk);
				chk(io_connector_out, 16'h0000);
			end
		load(20'hF_FFF1, 12'hF6F);
		pins(5'h01);
		chk(io_connector_out, 16'h0002);
		pins(5'h00);
		chk(io_connector_out, 16'h0000);
		load(20'hF_FFFF, 12'hFF3);
		chk(fwd_torque_limit, 16'h00C8);
		chk(torque_out, 16'h00C8);
		chk(io_connector_out, 16'h0001);
		load(20'hF_FF43, 12'hFF3);
		pins(5'h03);
		chk(fwd_torque_limit, 16'h0064);
		chk(rev_torque_limit, 16'h0064);
		chk(torque_out, 16'h0064);
		pins(5'h00);
		{pos_torque_cap_obj, motor_max_torque} = {9'h15E, 9'h096};
		repeat (3) @(negedge clk);
		chk(fwd_torque_limit, 16'h0096);
		{rev_internal_cap, torque_request_rev, torque_request} = {9'h040, 1'b1, 9'h050};
		repeat (3) @(negedge clk);
		chk(torque_out, 16'h0040);
		chk(torque_clamped_out, 16'h0001);
		torque_request = 9'h030;
		repeat (3) @(negedge clk);
		chk(torque_out, 16'h0030);
		chk(torque_clamped_out, 16'h0000);
		complete_run();
	end
endmodule : servo_io_signal_allocation_bench
